/* lei_pkg.sv */
package lei_pkg;
	// ==========================================
	// Register map (special-function-register bus)
	localparam logic [7:0] LEI_ENABLE_ADDR = 8'hC7;
	localparam logic [7:0] LEI_FLAG_ADDR = 8'hE8;
	localparam logic [7:0] LEI_OUT_ADDR = 8'hD1;
	localparam logic [7:0] LEI_ENABLE_RESET = 8'h00;
	localparam logic [7:0] LEI_FLAG_RESET = 8'h00;
	// ==========================================
	// Field layout: unit n uses bits 2n+1 (rise) and 2n (fall)
	localparam int LEI_UNITS = 4;
	localparam int LEI_RISE_OFS = 1;
	localparam int LEI_FALL_OFS = 0;
	localparam int LEI_SYNC_STAGES = 3;
	// ==========================================
	// Bus request carrier
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lei_req_t;
endpackage

/* lei_edge_det.sv */
`timescale 1ns/10ps
// ==========================================
// Synchronise one unit output and report its edges
module lei_edge_det
	import lei_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Unit output and its events
	input wire logic unit_out,
	output logic level,
	output logic rise,
	output logic fall
);
	logic [2:0] sync_reg;
	logic level_reg;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			sync_reg <= 3'h0;
			level_reg <= 1'b0;
		end else begin
			sync_reg <= {sync_reg[1:0], unit_out};
			// Change counts only once stages two and three agree
			if (sync_reg[1] == sync_reg[2]) begin
				level_reg <= sync_reg[2];
			end
		end
	end

	assign level = level_reg;
	assign rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;
	assign fall = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && level_reg;

	chk_rise_after_sync: assert property (@(posedge clock) disable iff (!resetn)
		rise |-> sync_reg[2] && $past(sync_reg[1]))
	else $error("Rise reported before synchroniser settled");
endmodule // lei_edge_det

/* lei_irq_enable.sv */
`timescale 1ns/10ps
module lei_irq_enable
	import lei_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register bus
	input wire lei_req_t req,
	output logic [7:0] rdata,
	// Logic units
	input wire logic [3:0] unit_raw_out,
	input wire logic [3:0] unit_enable,
	// Processor interrupt
	output logic irq
);
	// ==========================================
	// Decode
	logic [7:0] enable_reg;
	logic [7:0] enable_next;
	logic [7:0] flag_reg;
	logic [7:0] flag_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic irq_reg;
	logic irq_next;
	logic [3:0] gated_out;
	logic [3:0] level;
	logic [7:0] edge_set;
	wire sel_enable;
	wire sel_flag;
	wire sel_out;
	wire wr_enable;
	wire wr_flag;

	// Address match, shared by the write and the read paths
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] b);
		return a == b;
	endfunction

	assign sel_enable = addr_hit(req.addr, LEI_ENABLE_ADDR);
	assign sel_flag = addr_hit(req.addr, LEI_FLAG_ADDR);
	assign sel_out = addr_hit(req.addr, LEI_OUT_ADDR);
	// Other addresses are ignored on write and read as zero
	assign wr_enable = req.wr && sel_enable;
	assign wr_flag = req.wr && sel_flag;

	// Gate before the synchroniser so a disabled unit makes no edges after the fall that disabling a high unit gives
	assign gated_out = unit_raw_out & unit_enable;

	// ==========================================
	// Per-unit edge detectors
	genvar gi;
	generate
		for (gi = 0; gi < LEI_UNITS; gi++) begin : g_unit
			logic r;
			logic f;
			lei_edge_det u_det (
				.clock(clock),
				.resetn(resetn),
				.unit_out(gated_out[gi]),
				.level(level[gi]),
				.rise(r),
				.fall(f)
			);
			assign edge_set[2 * gi + LEI_RISE_OFS] = r;
			assign edge_set[2 * gi + LEI_FALL_OFS] = f;

			// Three stages, the level update and the sampling edge make five edges; the gate is combinational
			chk_disabled_silent: assert property (@(posedge clock)
				disable iff (!resetn)
				(!unit_enable[gi])[*5] |-> !level[gi])
			else $error("Disabled unit still shows a high level");
		end
	endgenerate

	// ==========================================
	// Next values
	assign enable_next = wr_enable ? req.wdata : enable_reg;
	// Software writes zeros to clear; a new edge in the same cycle wins
	assign flag_next = (wr_flag ? (flag_reg & req.wdata) : flag_reg)
		| edge_set;
	// Bits 7 and 6 gate unit three, lower pairs the rest
	assign irq_next = |(flag_next & enable_next);
	assign rdata_next = sel_enable ? enable_reg :
		sel_flag ? flag_reg :
		sel_out ? {4'h0, level} : 8'h00;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			enable_reg <= LEI_ENABLE_RESET;
			flag_reg <= LEI_FLAG_RESET;
			irq_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			enable_reg <= enable_next;
			flag_reg <= flag_next;
			irq_reg <= irq_next;
			rdata_reg <= req.rd ? rdata_next : rdata_reg;
		end
	end

	assign rdata = rdata_reg;
	assign irq = irq_reg;

	// ==========================================
	// Checks
	chk_irq_tracks_flags: assert property (@(posedge clock)
		disable iff (!resetn)
		##1 irq == |($past(flag_next) & $past(enable_next)))
	else $error("Interrupt request disagrees with enabled flags");

	chk_unit3_rise_gate: assert property (@(posedge clock)
		disable iff (!resetn)
		(flag_reg[7] && enable_reg[7]) |-> irq)
	else $error("Unit three rise flag enabled but no request");

	chk_unit3_fall_gate: assert property (@(posedge clock)
		disable iff (!resetn)
		(flag_reg[6] && enable_reg[6]) |-> irq)
	else $error("Unit three fall flag enabled but no request");

	chk_masked_quiet: assert property (@(posedge clock)
		disable iff (!resetn)
		##1 ($past(enable_next) == 8'h00) |-> !irq)
	else $error("Request with all enables clear");

	chk_flag_sticky: assert property (@(posedge clock)
		disable iff (!resetn)
		(flag_reg != 8'h00 && !wr_flag) |=> (flag_reg & $past(flag_reg))
			== $past(flag_reg))
	else $error("Edge flag dropped without a software clear");

	chk_edge_sets_flag: assert property (@(posedge clock)
		disable iff (!resetn)
		(edge_set != 8'h00) |=> (flag_reg & $past(edge_set))
			== $past(edge_set))
	else $error("Edge did not set its flag");

	chk_low_units_gate: assert property (@(posedge clock)
		disable iff (!resetn)
		((flag_reg[5:0] & enable_reg[5:0]) != 6'h00) |-> irq)
	else $error("Lower unit flag enabled but no request");

	// Request is a pure function of the stored registers
	chk_irq_exact: assert property (@(posedge clock)
		disable iff (!resetn)
		irq == |(flag_reg & enable_reg))
	else $error("Request differs from enabled flags");

	chk_irq_after_clear: assert property (@(posedge clock)
		disable iff (!resetn)
		(wr_flag && req.wdata == 8'h00 && edge_set == 8'h00)
			|=> !irq)
	else $error("Request stayed up after all flags cleared");

	chk_flag_only_by_edge: assert property (@(posedge clock)
		disable iff (!resetn)
		##1 ((flag_reg & ~$past(flag_reg) & ~$past(edge_set))
			== 8'h00))
	else $error("Flag set without an edge");

	chk_flag_write_clears: assert property (@(posedge clock)
		disable iff (!resetn)
		wr_flag |=> (flag_reg & ~$past(req.wdata) & ~$past(edge_set))
			== 8'h00)
	else $error("Written zero did not clear its flag");

	chk_flag_write_keeps: assert property (@(posedge clock)
		disable iff (!resetn)
		wr_flag |=> (flag_reg & $past(flag_reg & req.wdata))
			== $past(flag_reg & req.wdata))
	else $error("Written one dropped its flag");

	// ==========================================
	// Register bus checks, then the rise and fall pairing check
	chk_enable_lands: assert property (@(posedge clock)
		disable iff (!resetn)
		wr_enable |=> enable_reg == $past(req.wdata))
	else $error("Enable write did not land");

	chk_enable_held: assert property (@(posedge clock)
		disable iff (!resetn)
		!wr_enable |=> $stable(enable_reg))
	else $error("Enable register changed without a write");

	chk_rdata_holds: assert property (@(posedge clock)
		disable iff (!resetn)
		!req.rd |=> $stable(rdata))
	else $error("Read data moved without a read");

	chk_read_enable: assert property (@(posedge clock)
		disable iff (!resetn)
		(req.rd && sel_enable) |=> rdata == $past(enable_reg))
	else $error("Enable read returned a wrong value");

	chk_read_out_state: assert property (@(posedge clock)
		disable iff (!resetn)
		(req.rd && sel_out) |=> rdata == {4'h0, $past(level)})
	else $error("Output state read returned a wrong value");

	chk_unmapped_read: assert property (@(posedge clock)
		disable iff (!resetn)
		(req.rd && !sel_enable && !sel_flag && !sel_out)
			|=> rdata == 8'h00)
	else $error("Unmapped read returned nonzero");

	chk_no_double_edge: assert property (@(posedge clock)
		disable iff (!resetn)
		(edge_set & (edge_set >> 1) & 8'h55) == 8'h00)
	else $error("Rise and fall reported together");
endmodule // lei_irq_enable

/* lei_unit_model.sv */
`timescale 1ns/10ps
// ==========================================
// Logic unit outputs
module lei_unit_model
	import lei_pkg::*;
(
	// Clock
	input wire logic clock,
	// Levels
	input wire logic [3:0] want,
	output logic [3:0] raw
);
	initial raw = 4'h0;
	// Skewed off the clock edge, like a free-running unit
	always @(negedge clock) begin
		raw <= #3 want;
	end
endmodule // lei_unit_model

/* lei_irq_enable_test.sv */
`timescale 1ns/10ps
module lei_irq_enable_test
	import lei_pkg::*;
();
	logic clock = 1'b0;
	logic resetn = 1'b0;
	lei_req_t req = '0;
	logic [7:0] rdata;
	logic [3:0] want = 4'h0;
	logic [3:0] raw;
	logic [3:0] unit_enable = 4'hF;
	logic irq;
	logic [7:0] got;
	// Row: enable, unit, fall, irq
	logic [11:0] rows [8] = '{12'h021, 12'hFE2, 12'hF74, 12'h047,
		12'h209, 12'hEFA, 12'h7FC, 12'h40F};
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 clock = ~clock;
	lei_unit_model i_src (.clock(clock), .want(want), .raw(raw));
	lei_irq_enable i_dut (.clock(clock), .resetn(resetn), .req(req),
		.rdata(rdata), .unit_raw_out(raw), .unit_enable(unit_enable),
		.irq(irq));
	task automatic chk(input string w, input logic [7:0] e, a);
		n_tests++;
		if (a !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", w, e, a);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clock);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clock);
		req = '0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clock);
		req = '0;
		@(negedge clock);
		got = rdata;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		int u;
		logic f;
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		rd(LEI_ENABLE_ADDR);
		chk("enable", LEI_ENABLE_RESET, got);
		rd(LEI_FLAG_ADDR);
		chk("flags", LEI_FLAG_RESET, got);
		for (int i = 0; i < 8; i++) begin
			u = rows[i][3:2];
			f = rows[i][1];
			want = 4'h0;
			want[u] = f;
			repeat (8) @(negedge clock);
			wr(LEI_FLAG_ADDR, 8'h00);
			wr(LEI_ENABLE_ADDR, rows[i][11:4]);
			want[u] = !f;
			rd(LEI_FLAG_ADDR);
			chk("early flags", 8'h00, got);
			repeat (8) @(negedge clock);
			rd(LEI_FLAG_ADDR);
			chk("flags", 8'h01 << (2 * u + !f), got);
			chk("irq", {7'h00, rows[i][0]}, {7'h00, irq});
			rd(LEI_ENABLE_ADDR);
			chk("enable", rows[i][11:4], got);
			wr(LEI_FLAG_ADDR, 8'h00);
			chk("irq clear", 8'h00, {7'h00, irq});
			$display("row %0d done", i);
		end
		want = 4'hF;
		repeat (8) @(negedge clock);
		wr(LEI_FLAG_ADDR, 8'h00);
		unit_enable = 4'hE;
		repeat (8) @(negedge clock);
		wr(LEI_FLAG_ADDR, 8'hFF);
		rd(LEI_FLAG_ADDR);
		chk("disable fall", 8'h01, got);
		rd(LEI_OUT_ADDR);
		chk("out state", 8'h0E, got);
		wr(8'h10, 8'hFF);
		rd(8'h10);
		chk("unmapped", 8'h00, got);
		wr(LEI_ENABLE_ADDR, 8'hFF);
		chk("irq", 8'h01, {7'h00, irq});
		resetn = 1'b0;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		rd(LEI_ENABLE_ADDR);
		chk("enable", LEI_ENABLE_RESET, got);
		chk("irq", 8'h00, {7'h00, irq});
		$display("hand tests done");
		final_report();
	end
endmodule // lei_irq_enable_test
